// [pkg/dsbt_map.svh]
// Notes on behaviour
// - Vertical offset toggles every frame; amplitude from vertical moire control value.
// - Converter set: source 0 delay after mid-flyback; source 1 chosen line-drive edge.
// - Converter output turns on only after the trigger one-shot pulse ends.
// - Current-limit comparator resets the converter flip-flop, ending on-time.
// - Regulation comparator also resets the flip-flop, ORed with current limit.
// - Line drive turns on before converter drive, and off after it.
// - Over-voltage inhibits both drives after a two-line delay ignoring spikes.
// - An over-voltage trip sets the alarm flag readable by the host.
// - Over-voltage stays latched until supply drop or host clear bit.
// - Early blanking starts at first leading edge of vertical sync or discharge.
// - Early blanking ends at trailing edge of vertical discharge pulse.
// - Permanent-blank select high holds composite at blanking level for lock state.
// - Low supply, over-voltage or vertical drive disabled force permanent blanking.
// - Lock state and blanking state encode together as four composite levels.
// - Line drive inactive high in flyback, low supply, over-voltage, or once the soft stop after disable ends.
// - Soft start ramps from maximum off-duty to programmed duty; stop reverses.
`ifndef DSBT_MAP_SVH
`define DSBT_MAP_SVH
`define DSBT_CLK_NS 40
`define DSBT_TRIG_DELAY_NS 2000
`define DSBT_TRIG_DELAY_CYC ((`DSBT_TRIG_DELAY_NS + `DSBT_CLK_NS - 1) / `DSBT_CLK_NS)
`define DSBT_ONESHOT_NS 200
`define DSBT_ONESHOT_CYC ((`DSBT_ONESHOT_NS + `DSBT_CLK_NS - 1) / `DSBT_CLK_NS)
`define DSBT_OV_LINES 2'h2
`define DSBT_OFF_MAX 8'hff
`define DSBT_CNT_MAX 8'hff
`define DSBT_BLANK_BIT 0
`define DSBT_LOCK_BIT 1
`endif

// [pkg/dsbt_pkg.sv]
package dsbt_pkg;
  // Soft phase sequencing of the two drives
  typedef enum logic [1:0] {
    PH_OFF = 2'b00,
    PH_RISE = 2'b01,
    PH_BOTH = 2'b10,
    PH_FALL = 2'b11
  } dsbt_phase_type;

  // Control bits from the host side
  typedef struct packed {
    logic line_drive_enable;
    logic vert_drive_enable;
    logic permanent_blank_sel;
    logic conv_trigger_source_sel;
    logic conv_trigger_edge_sel;
    logic overvoltage_clear_bit;
    logic [7:0] line_drive_duty;
    logic [7:0] vert_moire_amplitude;
  } dsbt_ctrl_type;

  // Synchronised pin inputs, bit order fixed
  typedef struct packed {
    logic flyback;
    logic overvoltage_sense_in;
    logic current_limit;
    logic regulation;
    logic vsync;
    logic vert_discharge;
    logic supply_ok;
    logic line_lock;
  } dsbt_pins_type;

  // Whole state of the top module
  typedef struct packed {
    dsbt_phase_type phase;
    logic [7:0] line_cnt;
    logic [7:0] fb_cnt;
    logic [7:0] fb_len;
    logic fly_prev;
    logic [7:0] soft_off;
    logic [1:0] ov_cnt;
    logic ov_latch;
    logic force_prev;
    logic [3:0] os_cnt;
    logic conv_ff;
    logic line_out;
    logic line_prev;
    logic vs_prev;
    logic vd_prev;
    logic vblank;
    logic moire_ph;
    logic [7:0] moire_off;
    logic [1:0] composite;
  } dsbt_state_type;
endpackage

// [design/dsbt_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module dsbt_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] val;
  } dsbt_sync_type;

  dsbt_sync_type st_q, st_d;

  // Three stages; value moves once stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.val[i] = st_q.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.val;
endmodule // dsbt_sync
`default_nettype wire

// [design/dsbt_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dsbt_map.svh"
module dsbt_top (
  input wire logic clock,
  input wire logic resetn,
  input wire dsbt_pkg::dsbt_ctrl_type ctrl,
  input wire dsbt_pkg::dsbt_pins_type pins,
  output logic line_drive_out,
  output logic converter_drive_out,
  output logic overvoltage_alarm_flag,
  output logic [1:0] lock_blank_composite_out,
  output logic vert_moire_phase,
  output logic [7:0] vert_moire_offset
);
  import dsbt_pkg::*;

  localparam logic [7:0] TRIG_DELAY = 8'(`DSBT_TRIG_DELAY_CYC);
  localparam logic [3:0] ONESHOT = 4'(`DSBT_ONESHOT_CYC);

  dsbt_pins_type ps;
  dsbt_state_type st_q, st_d;
  logic line_start;
  logic force_off;
  logic trig;
  logic conv_reset;
  logic [7:0] trig_pt;
  logic line_act;

  // Pin inputs cross into the clock domain
  dsbt_sync #(.WIDTH(8)) u_sync (
    .clock(clock),
    .resetn(resetn),
    .din(pins),
    .dout(ps)
  );

  // Next-state logic
  always_comb begin
    st_d = st_q;
    line_start = ps.flyback && !st_q.fly_prev;
    force_off = !ps.supply_ok || st_q.ov_latch;
    st_d.fly_prev = ps.flyback;
    st_d.force_prev = force_off;

    // Line timing and flyback width
    if (line_start) begin
      st_d.line_cnt = 8'h00;
      st_d.fb_cnt = 8'h00;
    end else begin
      if (st_q.line_cnt != `DSBT_CNT_MAX) begin
        st_d.line_cnt = st_q.line_cnt + 8'h01;
      end
      if (ps.flyback && st_q.fb_cnt != `DSBT_CNT_MAX) begin
        st_d.fb_cnt = st_q.fb_cnt + 8'h01;
      end
    end
    if (!ps.flyback && st_q.fly_prev) begin
      st_d.fb_len = st_q.fb_cnt;
    end

    // Two-line debounce of over-voltage
    if (!ps.overvoltage_sense_in) begin
      st_d.ov_cnt = 2'h0;
    end else if (line_start && st_q.ov_cnt != `DSBT_OV_LINES) begin
      st_d.ov_cnt = st_q.ov_cnt + 2'h1;
    end
    // Latched trip; set wins over clear or supply drop
    if (st_d.ov_cnt == `DSBT_OV_LINES) begin
      st_d.ov_latch = 1'b1;
    end else if (ctrl.overvoltage_clear_bit || !ps.supply_ok) begin
      st_d.ov_latch = 1'b0;
    end

    // Soft phase-in and phase-out sequencing
    case (st_q.phase)
      PH_OFF: begin
        st_d.soft_off = `DSBT_OFF_MAX;
        if (ctrl.line_drive_enable && !force_off) begin
          st_d.phase = PH_RISE;
        end
      end
      PH_RISE: begin
        if (force_off || !ctrl.line_drive_enable) begin
          st_d.phase = PH_FALL;
        end else if (st_q.soft_off <= ctrl.line_drive_duty) begin
          st_d.phase = PH_BOTH;
        end else if (line_start) begin
          st_d.soft_off = st_q.soft_off - 8'h01;
        end
      end
      PH_BOTH: begin
        st_d.soft_off = ctrl.line_drive_duty;
        if (force_off || !ctrl.line_drive_enable) begin
          st_d.phase = PH_FALL;
        end
      end
      PH_FALL: begin
        if (force_off || st_q.soft_off == `DSBT_OFF_MAX) begin
          st_d.phase = PH_OFF;
        end else if (line_start) begin
          st_d.soft_off = st_q.soft_off + 8'h01;
        end
      end
      default: begin
        st_d.phase = PH_OFF;
      end
    endcase

    // Line drive, high means inactive; faults reach it one cycle after the converter
    line_act = (st_q.phase != PH_OFF) && !ps.flyback && !st_q.force_prev
      && (st_q.line_cnt >= st_q.soft_off);
    st_d.line_out = !line_act;
    st_d.line_prev = st_q.line_out;

    // Converter set trigger
    trig_pt = {1'b0, st_q.fb_len[7:1]} + TRIG_DELAY;
    if (!ctrl.conv_trigger_source_sel) begin
      trig = !line_start && (st_q.line_cnt == trig_pt);
    end else if (ctrl.conv_trigger_edge_sel) begin
      trig = st_q.line_out && !st_q.line_prev;
    end else begin
      trig = !st_q.line_out && st_q.line_prev;
    end

    // One-shot then set; any reset cause wins
    conv_reset = ps.current_limit || ps.regulation || force_off || (st_d.phase != PH_BOTH);
    if (trig && st_q.phase == PH_BOTH) begin
      st_d.os_cnt = ONESHOT;
    end else if (st_q.os_cnt != 4'h0) begin
      st_d.os_cnt = st_q.os_cnt - 4'h1;
    end
    if (conv_reset) begin
      st_d.conv_ff = 1'b0;
    end else if (st_q.os_cnt == 4'h1) begin
      st_d.conv_ff = 1'b1;
    end

    // Early vertical blanking
    st_d.vs_prev = ps.vsync;
    st_d.vd_prev = ps.vert_discharge;
    if ((ps.vsync && !st_q.vs_prev) || (ps.vert_discharge && !st_q.vd_prev)) begin
      st_d.vblank = 1'b1;
    end else if (!ps.vert_discharge && st_q.vd_prev) begin
      st_d.vblank = 1'b0;
    end

    // Composite lock and blank level
    st_d.composite[`DSBT_LOCK_BIT] = ps.line_lock;
    st_d.composite[`DSBT_BLANK_BIT] = st_d.vblank || ctrl.permanent_blank_sel
      || force_off || !ctrl.vert_drive_enable;

    // Per-frame moire toggle
    if (ps.vsync && !st_q.vs_prev) begin
      st_d.moire_ph = !st_q.moire_ph;
    end
    st_d.moire_off = st_d.moire_ph ? ctrl.vert_moire_amplitude : 8'h00;
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{phase: PH_OFF, soft_off: `DSBT_OFF_MAX, line_out: 1'b1, line_prev: 1'b1,
                composite: 2'h1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign line_drive_out = st_q.line_out;
  assign converter_drive_out = st_q.conv_ff;
  assign overvoltage_alarm_flag = st_q.ov_latch;
  assign lock_blank_composite_out = st_q.composite;
  assign vert_moire_phase = st_q.moire_ph;
  assign vert_moire_offset = st_q.moire_off;

  // Checks
  property p_trip_needs_sense;
    @(posedge clock) disable iff (!resetn) $rose(overvoltage_alarm_flag) |-> $past(ps.overvoltage_sense_in);
  endproperty
  a_trip_needs_sense: assert property (p_trip_needs_sense) else $error("alarm without sense");

  property p_debounce_restart;
    @(posedge clock) disable iff (!resetn) !ps.overvoltage_sense_in |=> st_q.ov_cnt == 2'h0;
  endproperty
  a_debounce_restart: assert property (p_debounce_restart) else $error("debounce not cleared");

  property p_alarm_held;
    @(posedge clock) disable iff (!resetn)
      overvoltage_alarm_flag && ps.supply_ok && !ctrl.overvoltage_clear_bit |=> overvoltage_alarm_flag;
  endproperty
  a_alarm_held: assert property (p_alarm_held) else $error("alarm dropped");

  property p_line_off_ovp;
    @(posedge clock) disable iff (!resetn) overvoltage_alarm_flag [*2] |=> line_drive_out;
  endproperty
  a_line_off_ovp: assert property (p_line_off_ovp) else $error("line active in alarm");

  property p_conv_off_force;
    @(posedge clock) disable iff (!resetn) (overvoltage_alarm_flag || !ps.supply_ok) |=> !converter_drive_out;
  endproperty
  a_conv_off_force: assert property (p_conv_off_force) else $error("converter on in fault");

  property p_curlim_reset;
    @(posedge clock) disable iff (!resetn) ps.current_limit |=> !converter_drive_out;
  endproperty
  a_curlim_reset: assert property (p_curlim_reset) else $error("current limit ignored");

  property p_reg_reset;
    @(posedge clock) disable iff (!resetn) ps.regulation |=> !converter_drive_out;
  endproperty
  a_reg_reset: assert property (p_reg_reset) else $error("regulation ignored");

  property p_conv_after_pulse;
    @(posedge clock) disable iff (!resetn) $rose(converter_drive_out) |-> $past(st_q.os_cnt) == 4'h1;
  endproperty
  a_conv_after_pulse: assert property (p_conv_after_pulse) else $error("set before pulse end");

  property p_conv_in_both;
    @(posedge clock) disable iff (!resetn) converter_drive_out |-> st_q.phase == PH_BOTH;
  endproperty
  a_conv_in_both: assert property (p_conv_in_both) else $error("converter outside run phase");

  property p_blank_start;
    @(posedge clock) disable iff (!resetn) ($rose(ps.vsync) || $rose(ps.vert_discharge)) |=> st_q.vblank;
  endproperty
  a_blank_start: assert property (p_blank_start) else $error("blank not started");

  property p_blank_end;
    @(posedge clock) disable iff (!resetn) $fell(ps.vert_discharge) && !$rose(ps.vsync) |=> !st_q.vblank;
  endproperty
  a_blank_end: assert property (p_blank_end) else $error("blank not ended");

  property p_force_blank;
    @(posedge clock) disable iff (!resetn)
      (!ps.supply_ok || !ctrl.vert_drive_enable || ctrl.permanent_blank_sel) |=> lock_blank_composite_out[0];
  endproperty
  a_force_blank: assert property (p_force_blank) else $error("blank not forced");

  property p_moire_toggle;
    @(posedge clock) disable iff (!resetn) $rose(ps.vsync) |=> vert_moire_phase != $past(vert_moire_phase);
  endproperty
  a_moire_toggle: assert property (p_moire_toggle) else $error("moire not toggled");

  c_conv_on: cover property (@(posedge clock) disable iff (!resetn) $rose(converter_drive_out));
  c_trip: cover property (@(posedge clock) disable iff (!resetn) $rose(overvoltage_alarm_flag));
  c_soft_stop: cover property (@(posedge clock) disable iff (!resetn) st_q.phase == PH_FALL);
  c_vblank: cover property (@(posedge clock) disable iff (!resetn) $fell(st_q.vblank));
endmodule // dsbt_top
`default_nettype wire

// [bench/dsbt_stage_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dsbt_stage_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic converter_drive_out,
  input wire logic use_regulation,
  input wire logic [7:0] on_limit,
  output logic flyback,
  output logic current_limit,
  output logic regulation
);
  logic [8:0] pos_q;
  logic [7:0] on_q;
  // Line of 300 clocks, conduction time of the switch
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pos_q <= 9'h000;
      on_q <= 8'h00;
    end else begin
      pos_q <= (pos_q == 9'h12b) ? 9'h000 : pos_q + 9'h001;
      on_q <= !converter_drive_out ? 8'h00 : (on_q == 8'hff) ? on_q : on_q + 8'h01;
    end
  end
  // Flyback pulse of 8 clocks at each line start
  assign flyback = (pos_q < 9'h008);
  // Sense ramp crosses a threshold after on_limit clocks, falls when switch opens
  assign current_limit = !use_regulation && converter_drive_out && (on_q >= on_limit);
  assign regulation = use_regulation && converter_drive_out && (on_q >= on_limit);
endmodule // dsbt_stage_model
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dsbt_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  dsbt_ctrl_type ctrl;
  dsbt_pins_type pins;
  logic fly, lim, regl, ov_s, vs, vd, sup, lock, use_reg;
  logic line_drive_out, converter_drive_out, overvoltage_alarm_flag, vert_moire_phase;
  logic [1:0] lock_blank_composite_out;
  logic [7:0] vert_moire_offset;
  int mismatches = 0;
  int n_compared = 0;
  int n;
  logic line_seen;
  always #20 clock = ~clock;
  assign pins = {fly, ov_s, lim, regl, vs, vd, sup, lock};
  dsbt_top dut (.clock(clock), .resetn(resetn), .ctrl(ctrl), .pins(pins), .line_drive_out(line_drive_out),
    .converter_drive_out(converter_drive_out), .overvoltage_alarm_flag(overvoltage_alarm_flag),
    .lock_blank_composite_out(lock_blank_composite_out), .vert_moire_phase(vert_moire_phase),
    .vert_moire_offset(vert_moire_offset));
  dsbt_stage_model far (.clock(clock), .resetn(resetn), .converter_drive_out(converter_drive_out),
    .use_regulation(use_reg), .on_limit(8'h14), .flyback(fly), .current_limit(lim), .regulation(regl));
  // Watched signals by number
  function automatic logic sig(input int s);
    case (s)
      0: return fly;
      1: return line_drive_out;
      2: return !line_drive_out;
      3: return converter_drive_out;
      4: return !converter_drive_out;
      5: return overvoltage_alarm_flag;
      default: return lock_blank_composite_out[0];
    endcase
  endfunction
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #2;
  endtask
  task automatic fail(input string what);
    mismatches++;
    $display("[ERR] %0t %s", $time, what);
  endtask
  task automatic chk(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail(what);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi, input string what);
    n_compared++;
    if (v < lo || v > hi) begin
      fail(what);
    end
  endtask
  // Bounded wait for a level, k gives the cycles taken
  task automatic wait_for(input int s, input logic val, input int bound, output int k);
    k = 0;
    while (sig(s) !== val && k < bound) begin
      tick(1);
      k++;
    end
    if (sig(s) !== val) begin
      fail("wait timed out");
      give_verdict();
    end
  endtask
  // Cycles from a rise of signal a to signal b high
  task automatic gap(input int a, input int b, output int k);
    wait_for(a, 1'b0, 700, k);
    wait_for(a, 1'b1, 700, k);
    wait_for(b, 1'b1, 400, k);
  endtask
  initial begin
    ctrl = '0;
    ctrl.permanent_blank_sel = 1'b1;
    ctrl.vert_drive_enable = 1'b1;
    ctrl.line_drive_duty = 8'hf0;
    ctrl.vert_moire_amplitude = 8'h5a;
    {ov_s, vs, vd, use_reg} = 4'h0;
    {sup, lock} = 2'h3;
    tick(8);
    resetn = 1'b1;
    chk(line_drive_out, 1'b1, "line not idle");
    chk(converter_drive_out, 1'b0, "conv not idle");
    chk(lock_blank_composite_out[0], 1'b1, "no default blank");
    ctrl.permanent_blank_sel = 1'b0;
    tick(6);
    chk(lock_blank_composite_out === 2'h2, 1'b1, "composite level");
    // Sync first, then discharge first
    for (int i = 0; i < 2; i++) begin
      if (i == 0) vs = 1'b1; else vd = 1'b1;
      wait_for(6, 1'b1, 8, n);
      tick(4);
      {vs, vd} = 2'h3;
      tick(10);
      vs = 1'b0;
      tick(10);
      chk(lock_blank_composite_out[0], 1'b1, "blank ended early");
      chk(vert_moire_phase, (i == 0), "moire phase");
      chk(vert_moire_offset === ((i == 0) ? 8'h5a : 8'h00), 1'b1, "moire offset");
      vd = 1'b0;
      wait_for(6, 1'b0, 8, n);
    end
    lock = 1'b0;
    tick(6);
    chk(lock_blank_composite_out[1], 1'b0, "lock bit");
    ctrl.vert_drive_enable = 1'b0;
    tick(3);
    chk(lock_blank_composite_out[0], 1'b1, "vertical off no blank");
    ctrl.vert_drive_enable = 1'b1;
    $display("test blanking done");
    ctrl.line_drive_enable = 1'b1;
    n = 0;
    line_seen = 1'b0;
    while (converter_drive_out !== 1'b1 && n < 6000) begin
      if (line_drive_out === 1'b0) line_seen = 1'b1;
      tick(1);
      n++;
    end
    chk(line_seen, 1'b1, "conv before line");
    rng(n, 3000, 5999, "soft start length");
    gap(0, 3, n);
    rng(n, 50, 75, "conv set after flyback");
    wait_for(0, 1'b1, 400, n);
    tick(5);
    chk(line_drive_out, 1'b1, "line active in flyback");
    for (int i = 0; i < 2; i++) begin
      use_reg = i[0];
      gap(3, 4, n);
      rng(n, 20, 30, "on-time not cut");
    end
    use_reg = 1'b0;
    ctrl.conv_trigger_source_sel = 1'b1;
    for (int i = 0; i < 2; i++) begin
      ctrl.conv_trigger_edge_sel = i[0];
      gap(2 - i, 3, n);
      rng(n, 5, 9, "conv after line edge");
    end
    ctrl.conv_trigger_source_sel = 1'b0;
    $display("test converter done");
    // Spike across one line start, then held sense
    wait_for(0, 1'b1, 400, n);
    tick(200);
    ov_s = 1'b1;
    tick(150);
    ov_s = 1'b0;
    tick(100);
    chk(overvoltage_alarm_flag, 1'b0, "spike tripped");
    ov_s = 1'b1;
    wait_for(5, 1'b1, 1000, n);
    rng(n, 300, 700, "trip timing");
    tick(3);
    chk(line_drive_out & ~converter_drive_out & lock_blank_composite_out[0], 1'b1, "drives on");
    ov_s = 1'b0;
    tick(700);
    chk(overvoltage_alarm_flag & line_drive_out, 1'b1, "trip not held");
    ctrl.overvoltage_clear_bit = 1'b1;
    tick(1);
    ctrl.overvoltage_clear_bit = 1'b0;
    tick(3);
    chk(overvoltage_alarm_flag, 1'b0, "alarm not cleared");
    wait_for(3, 1'b1, 6000, n);
    $display("test overvoltage done");
    ctrl.line_drive_enable = 1'b0;
    tick(3);
    chk(converter_drive_out, 1'b0, "conv still on at stop");
    wait_for(2, 1'b1, 700, n);
    sup = 1'b0;
    tick(6);
    chk(line_drive_out & ~converter_drive_out & lock_blank_composite_out[0], 1'b1, "low supply");
    $display("test stop done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
